// >>> hw/aolc_map.svh
`ifndef AOLC_MAP_SVH
`define AOLC_MAP_SVH

// Register indexes; byte address is four times the index
`define AOLC_IDX_FORMAT      8'h3d
`define AOLC_IDX_IFACE       8'h41
`define AOLC_IDX_SHORTPATH   8'h42
`define AOLC_IDX_LOOP        8'hcf
`define AOLC_IDX_SPEED       8'hdf
`define AOLC_IDX_STATUS      8'hf0

// Reset values
`define AOLC_RST_FORMAT      8'h00
`define AOLC_RST_IFACE       8'h00
`define AOLC_RST_SHORTPATH   8'h00
`define AOLC_RST_LOOP        8'h00
`define AOLC_RST_SPEED       8'h00

// Field positions
`define AOLC_FMT_SEL_HI      7
`define AOLC_FMT_SEL_LO      6
`define AOLC_FMT_CANCEL_BIT  5
`define AOLC_IF_SEL_HI       7
`define AOLC_IF_SEL_LO       6
`define AOLC_SP_OFF_BIT      3
`define AOLC_LOOP_HOLD_BIT   7
`define AOLC_LOOP_SEL_HI     5
`define AOLC_LOOP_SEL_LO     2
`define AOLC_SPD_HI          5
`define AOLC_SPD_LO          4
`define AOLC_STAT_OVF_BIT    31
`define AOLC_STAT_ACT_BIT    30

// Field codes
`define AOLC_FMT_PIN         2'h0
`define AOLC_FMT_TWOS        2'h2
`define AOLC_IF_LVDS         2'h1
`define AOLC_IF_CMOS         2'h3
`define AOLC_SPD_LOW         2'h3

// Loop period: code 0 is 2**20 cycles, highest legal code 4'hb
`define AOLC_LOOP_BASE_LOG2  6'h14
`define AOLC_LOOP_MAX_CODE   4'hb

// Conversion latency in sample clock cycles, and output buffer depth in words
`define AOLC_LATENCY         10
`define AOLC_FIFO_DEPTH      8

`endif

// >>> hw/aolc_pkg.sv
package aolc_pkg;

    typedef enum logic [1:0] {
        AOLC_IDLE,
        AOLC_ACCESS
    } aolc_bus_state_type;

    typedef logic [7:0] aolc_reg_type;

endpackage : aolc_pkg

// >>> hw/aolc_top.sv
// How it works
// - Loop period code 0 is 1M cycles, each step doubles, code 11 is 2G.
// - Speed register resets to zero; only bits five and four hold the field.
// - Lower-rate variant runs low-speed after reset; host never writes field.
// - Higher-rate variant: codes 00, 01, 10 keep low-speed off, reset state.
// - Higher-rate variant: code 11 turns low-speed mode on.
// - Each conversion samples the input on the rising sample clock edge.
// - A sample reaches the data outputs ten clock cycles after sampling.
// - Words are 14 or 12 bits, LVDS or CMOS, offset binary or two's.
// - Hold bit with correction on freezes the estimate, still applied.
// - Correction works only while its enable bit is one.
// - Short-path bit zero bypasses offset correction.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns

module aolc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] memArr [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             wrEn;
    logic             popEn;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("aolc_fifo: DEPTH must be a power of two of at least 2");
    end

    assign wrEn  = inValid && inReady;
    assign popEn = (count_reg != '0) && (!outValid || outReady);

    always_comb begin
        count_next = count_reg;
        if (wrEn && !popEn) begin
            count_next = count_reg + (AW+1)'(1);
        end else if (popEn && !wrEn) begin
            count_next = count_reg - (AW+1)'(1);
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            inReady   <= 1'b0;
        end else begin
            if (wrEn) begin
                wrPtr_reg <= wrPtr_reg + AW'(1);
            end
            if (popEn) begin
                rdPtr_reg <= rdPtr_reg + AW'(1);
            end
            count_reg <= count_next;
            inReady   <= count_next != (AW+1)'(DEPTH);
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (wrEn) begin
            memArr[wrPtr_reg] <= inData;
        end
    end

    // Registered output stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outData  <= '0;
            outValid <= 1'b0;
        end else if (popEn) begin
            outData  <= memArr[rdPtr_reg];
            outValid <= 1'b1;
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end

endmodule : aolc_fifo

`include "aolc_map.svh"

module aolc_top #(
    parameter int RESOLUTION = 14,
    parameter bit LOW_RATE   = 1'b0,
    parameter int LATENCY    = `AOLC_LATENCY,
    parameter int FIFO_DEPTH = `AOLC_FIFO_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [9:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [RESOLUTION-1:0] rawSample,
    input  wire logic                  formatPin,
    input  wire logic                  interfacePin,
    output logic      [RESOLUTION-1:0] outData,
    output logic                       outValid,
    input  wire logic                  outReady,
    output logic                       lvdsSelect,
    output logic                       twosSelect,
    output logic                       lowSpeedActive,
    output logic                       correctionActive,
    output logic                       bufferReady
);
    localparam int STAGES = LATENCY - 1;
    localparam int ACC_W  = RESOLUTION + 33;
    localparam int DW     = RESOLUTION + 2;

    if (RESOLUTION != 14 && RESOLUTION != 12) begin : g_chkRes
        $error("aolc_top: RESOLUTION must be 12 or 14");
    end
    if (LATENCY < 3) begin : g_chkLat
        $error("aolc_top: LATENCY must be at least 3");
    end

    function automatic logic signed [RESOLUTION-1:0] toSigned(
        input logic [RESOLUTION-1:0] v
    );
        toSigned = {~v[RESOLUTION-1], v[RESOLUTION-2:0]};
    endfunction : toSigned

    function automatic logic [5:0] loopShift(input logic [3:0] code);
        logic [3:0] c;
        c = code;
        if (c > `AOLC_LOOP_MAX_CODE) begin
            c = `AOLC_LOOP_MAX_CODE;
        end
        loopShift = `AOLC_LOOP_BASE_LOG2 + {2'h0, c};
    endfunction : loopShift

    aolc_pkg::aolc_bus_state_type busState_reg;
    aolc_pkg::aolc_reg_type       format_reg;
    aolc_pkg::aolc_reg_type       iface_reg;
    aolc_pkg::aolc_reg_type       shortPath_reg;
    aolc_pkg::aolc_reg_type       loop_reg;
    aolc_pkg::aolc_reg_type       speed_reg;
    logic                         overflow_reg;
    logic [7:0]                   index;
    logic                         hit;
    logic [31:0]                  readValue;
    logic                         writeStrobe;

    logic [RESOLUTION-1:0]        pipe_reg [STAGES];
    logic [STAGES-1:0]            pipeValid_reg;
    logic signed [ACC_W-1:0]      acc_reg;
    logic signed [ACC_W-1:0]      accShifted;
    logic signed [RESOLUTION:0]   estimate;
    logic signed [DW-1:0]         sampleWide;
    logic signed [DW-1:0]         diff;
    logic signed [RESOLUTION-1:0] corrected;
    logic [RESOLUTION-1:0]        formatted;
    logic                         cancelOn;
    logic                         twosNow;
    logic                         fifoInReady;

    assign index = paddr[9:2];

    // Address decode
    always_comb begin
        hit       = 1'b1;
        readValue = '0;
        case (index)
            `AOLC_IDX_FORMAT: begin
                readValue[7:0] = format_reg;
            end
            `AOLC_IDX_IFACE: begin
                readValue[7:0] = iface_reg;
            end
            `AOLC_IDX_SHORTPATH: begin
                readValue[7:0] = shortPath_reg;
            end
            `AOLC_IDX_LOOP: begin
                readValue[7:0] = loop_reg;
            end
            `AOLC_IDX_SPEED: begin
                readValue[7:0] = speed_reg;
            end
            `AOLC_IDX_STATUS: begin
                readValue[RESOLUTION:0]          = estimate;
                readValue[`AOLC_STAT_ACT_BIT] = cancelOn;
                readValue[`AOLC_STAT_OVF_BIT] = overflow_reg;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    assign writeStrobe = psel && penable && pready && pwrite && hit;

    // Bus slave: one wait-free access phase after each setup
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busState_reg <= aolc_pkg::AOLC_IDLE;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= '0;
        end else begin
            case (busState_reg)
                aolc_pkg::AOLC_IDLE: begin
                    if (psel && !penable) begin
                        busState_reg <= aolc_pkg::AOLC_ACCESS;
                        pready       <= 1'b1;
                        pslverr      <= !hit;
                        prdata       <= pwrite ? 32'h0 : readValue;
                    end
                end
                aolc_pkg::AOLC_ACCESS: begin
                    busState_reg <= aolc_pkg::AOLC_IDLE;
                    pready       <= 1'b0;
                    pslverr      <= 1'b0;
                    prdata       <= '0;
                end
                default: begin
                    busState_reg <= aolc_pkg::AOLC_IDLE;
                    pready       <= 1'b0;
                end
            endcase
        end
    end

    // Configuration registers; reserved bits are dropped and read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            format_reg    <= `AOLC_RST_FORMAT;
            iface_reg     <= `AOLC_RST_IFACE;
            shortPath_reg <= `AOLC_RST_SHORTPATH;
            loop_reg      <= `AOLC_RST_LOOP;
            speed_reg     <= `AOLC_RST_SPEED;
        end else if (writeStrobe) begin
            case (index)
                `AOLC_IDX_FORMAT: begin
                    format_reg <= pwdata[7:0] & 8'he0;
                end
                `AOLC_IDX_IFACE: begin
                    iface_reg <= pwdata[7:0] & 8'hc0;
                end
                `AOLC_IDX_SHORTPATH: begin
                    shortPath_reg <= pwdata[7:0] & 8'h08;
                end
                `AOLC_IDX_LOOP: begin
                    loop_reg <= pwdata[7:0] & 8'hbc;
                end
                `AOLC_IDX_SPEED: begin
                    speed_reg <= pwdata[7:0] & 8'h30;
                end
                default: begin
                end
            endcase
        end
    end

    // Mode outputs
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lowSpeedActive   <= 1'b0;
            lvdsSelect       <= 1'b0;
            twosSelect       <= 1'b0;
            correctionActive <= 1'b0;
        end else begin
            if (LOW_RATE) begin
                lowSpeedActive <= 1'b1;
            end else begin
                lowSpeedActive <= speed_reg[`AOLC_SPD_HI:`AOLC_SPD_LO]
                                  == `AOLC_SPD_LOW;
            end
            case (iface_reg[`AOLC_IF_SEL_HI:`AOLC_IF_SEL_LO])
                `AOLC_IF_LVDS: lvdsSelect <= 1'b1;
                `AOLC_IF_CMOS: lvdsSelect <= 1'b0;
                default:       lvdsSelect <= interfacePin;
            endcase
            twosSelect       <= twosNow;
            correctionActive <= cancelOn;
        end
    end

    always_comb begin
        case (format_reg[`AOLC_FMT_SEL_HI:`AOLC_FMT_SEL_LO])
            `AOLC_FMT_PIN:  twosNow = formatPin;
            `AOLC_FMT_TWOS: twosNow = 1'b1;
            default:        twosNow = 1'b0;
        endcase
    end

    assign cancelOn = format_reg[`AOLC_FMT_CANCEL_BIT]
                      && shortPath_reg[`AOLC_SP_OFF_BIT];

    // Offset estimate and correction of the sample leaving the pipeline
    assign accShifted = acc_reg >>> loopShift(
        loop_reg[`AOLC_LOOP_SEL_HI:`AOLC_LOOP_SEL_LO]);
    assign estimate   = accShifted[RESOLUTION:0];
    assign sampleWide = DW'(toSigned(pipe_reg[STAGES-2]));
    assign diff       = sampleWide - DW'(estimate);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_reg <= '0;
        end else if (!cancelOn) begin
            acc_reg <= '0;
        end else if (!loop_reg[`AOLC_LOOP_HOLD_BIT]
                     && pipeValid_reg[STAGES-2]) begin
            acc_reg <= acc_reg + ACC_W'(diff);
        end
    end

    always_comb begin
        if (!cancelOn) begin
            corrected = toSigned(pipe_reg[STAGES-2]);
        end else if (diff > DW'($signed({1'b0, {(RESOLUTION-1){1'b1}}}))) begin
            corrected = {1'b0, {(RESOLUTION-1){1'b1}}};
        end else if (diff < DW'($signed({1'b1, {(RESOLUTION-1){1'b0}}})))
        begin
            corrected = {1'b1, {(RESOLUTION-1){1'b0}}};
        end else begin
            corrected = diff[RESOLUTION-1:0];
        end
        formatted = twosNow ? corrected
                  : {~corrected[RESOLUTION-1], corrected[RESOLUTION-2:0]};
    end

    // Conversion pipeline, one stage per rising sample edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pipeValid_reg <= '0;
        end else begin
            pipeValid_reg <= {pipeValid_reg[STAGES-2:0], 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        pipe_reg[0] <= rawSample;
        for (int i = 1; i < STAGES - 1; i++) begin
            pipe_reg[i] <= pipe_reg[i-1];
        end
        pipe_reg[STAGES-1] <= formatted;
    end

    // Sticky loss flag when the buffer is full
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overflow_reg <= 1'b0;
        end else if (pipeValid_reg[STAGES-1] && !fifoInReady) begin
            overflow_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bufferReady <= 1'b0;
        end else begin
            bufferReady <= fifoInReady;
        end
    end

    aolc_fifo #(
        .WIDTH (RESOLUTION),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inData   (pipe_reg[STAGES-1]),
        .inValid  (pipeValid_reg[STAGES-1]),
        .inReady  (fifoInReady),
        .outData  (outData),
        .outValid (outValid),
        .outReady (outReady)
    );

endmodule : aolc_top

// >>> test/aolc_capture_model.sv
`timescale 1ns/1ns

module aolc_capture_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic holdOff,
    input  wire logic slowMode,
    output logic      outReady
);
    // Capture side: prompt, every other cycle, or stalled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outReady <= 1'b0;
        end else begin
            outReady <= !holdOff && (!slowMode || !outReady);
        end
    end
endmodule : aolc_capture_model

// >>> test/aolc_top_sva.sv
`timescale 1ns/1ns
`include "aolc_map.svh"

module aolc_top_sva #(
    parameter int RESOLUTION = 14,
    parameter bit LOW_RATE   = 1'b0
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [9:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic [RESOLUTION-1:0] outData,
    input wire logic                  outValid,
    input wire logic                  outReady,
    input wire logic                  twosSelect,
    input wire logic                  lowSpeedActive,
    input wire logic                  correctionActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence setupSeq;
        psel && !penable;
    endsequence
    sequence wrSeq(logic [7:0] idx);
        psel && penable && pready && pwrite && paddr[9:2] == idx;
    endsequence
    sequence rdSeq(logic [7:0] idx);
        psel && penable && pready && !pwrite && paddr[9:2] == idx;
    endsequence
    a_ready_pulse: assert property (
        setupSeq |=> pready ##1 !pready) else $error("ready not one cycle");
    a_speed_on: assert property (
        wrSeq(`AOLC_IDX_SPEED) ##0 (!LOW_RATE && pwdata[5:4] == 2'h3)
        |-> ##[1:3] lowSpeedActive) else $error("low speed not on");
    a_speed_off: assert property (
        wrSeq(`AOLC_IDX_SPEED) ##0 (!LOW_RATE && pwdata[5:4] != 2'h3)
        |-> ##[1:3] !lowSpeedActive) else $error("low speed not off");
    a_low_rate: assert property (
        LOW_RATE && rst_n |=> lowSpeedActive)
        else $error("low rate not low speed");
    a_cancel_off: assert property (
        wrSeq(`AOLC_IDX_FORMAT) ##0 !pwdata[5] |-> ##[1:3] !correctionActive)
        else $error("correction stays on");
    a_path_off: assert property (
        wrSeq(`AOLC_IDX_SHORTPATH) ##0 !pwdata[3]
        |-> ##[1:3] !correctionActive) else $error("bypass keeps correction");
    a_twos_code: assert property (
        wrSeq(`AOLC_IDX_FORMAT) ##0 (pwdata[7:6] == 2'h2)
        |-> ##[1:3] twosSelect) else $error("twos code ignored");
    a_out_hold: assert property (
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("word not held");
    a_speed_bits: assert property (
        rdSeq(`AOLC_IDX_SPEED) |-> prdata[31:6] == 26'h0 && prdata[3:0] == 4'h0)
        else $error("speed reserved bits set");
    a_loop_bits: assert property (
        rdSeq(`AOLC_IDX_LOOP) |-> prdata[31:8] == 24'h0 && !prdata[6]
        && prdata[1:0] == 2'h0) else $error("loop reserved bits set");
    a_reset_clear: assert property (disable iff (1'b0)
        !rst_n |=> !pready && !outValid && !correctionActive)
        else $error("reset not clearing");
endmodule : aolc_top_sva

bind aolc_top aolc_top_sva #(.RESOLUTION(RESOLUTION), .LOW_RATE(LOW_RATE)) chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .outData(outData), .outValid(outValid),
    .outReady(outReady), .twosSelect(twosSelect),
    .lowSpeedActive(lowSpeedActive), .correctionActive(correctionActive)
);

// >>> test/tb.sv
`timescale 1ns/1ns
`include "aolc_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end

module tb;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, formatPin = 1'b0, interfacePin = 1'b0;
    logic [9:0]  paddr = 10'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdData;
    logic [13:0] rawSample = 14'h0, outData;
    logic        pready, pslverr, outValid, outReady, lvdsSelect, twosSelect;
    logic        lowSpeedActive, correctionActive, bufferReady, rdErr;
    logic        lowRateSpeed;
    logic        holdOff = 1'b0, slowMode = 1'b0;
    int          bad_count = 0, tests_run = 0;

    always #50 clk = ~clk;

    aolc_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rawSample(rawSample),
        .formatPin(formatPin), .interfacePin(interfacePin),
        .outData(outData), .outValid(outValid), .outReady(outReady),
        .lvdsSelect(lvdsSelect), .twosSelect(twosSelect),
        .lowSpeedActive(lowSpeedActive),
        .correctionActive(correctionActive), .bufferReady(bufferReady));
    // Lower-rate variant: the host never touches its registers
    aolc_top #(.LOW_RATE(1'b1)) DUT2 (.clk(clk), .rst_n(rst_n),
        .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(10'h0),
        .pwdata(32'h0), .prdata(), .pready(), .pslverr(),
        .rawSample(rawSample), .formatPin(formatPin),
        .interfacePin(interfacePin), .outData(), .outValid(),
        .outReady(1'b1), .lvdsSelect(), .twosSelect(),
        .lowSpeedActive(lowRateSpeed), .correctionActive(),
        .bufferReady());
    aolc_capture_model sink (.clk(clk), .rst_n(rst_n), .holdOff(holdOff),
        .slowMode(slowMode), .outReady(outReady));

    task end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            end_of_test();
        end
        @(posedge clk);
    endtask : apb

    task automatic t_regs;
        logic [7:0] idx [5] = '{8'h3d, 8'h41, 8'h42, 8'hcf, 8'hdf};
        foreach (idx[i]) begin
            apb(1'b0, idx[i], 8'h0);
            `CHK(rdData, 32'h0)
        end
        apb(1'b0, 8'h10, 8'h0);
        `CHK({rdErr, rdData}, 33'h100000000)
        apb(1'b1, `AOLC_IDX_LOOP, 8'hac);
        apb(1'b0, `AOLC_IDX_LOOP, 8'h0);
        `CHK(rdData, 32'hac)
        apb(1'b1, `AOLC_IDX_SPEED, 8'h30);
        apb(1'b0, `AOLC_IDX_SPEED, 8'h0);
        `CHK(rdData, 32'h30)
        apb(1'b1, `AOLC_IDX_LOOP, 8'h0);
    endtask : t_regs

    task automatic t_speed;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `AOLC_IDX_SPEED, {2'h0, c[1:0], 4'h0});
            cyc(3);
            `CHK(lowSpeedActive, (c == 3))
        end
        `CHK(lowRateSpeed, 1'b1)
        apb(1'b1, `AOLC_IDX_SPEED, 8'h0);
    endtask : t_speed

    task automatic t_pins;
        logic [1:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[1:0];
            formatPin    <= i[2];
            interfacePin <= i[2];
            apb(1'b1, `AOLC_IDX_FORMAT, {c, 6'h0});
            apb(1'b1, `AOLC_IDX_IFACE, {c, 6'h0});
            cyc(3);
            `CHK(lvdsSelect, (c == 2'h1) || (!c[0] && i[2]))
            `CHK(twosSelect, (c == 2'h2) || (c == 2'h0 && i[2]))
        end
        formatPin <= 1'b0;
        apb(1'b1, `AOLC_IDX_FORMAT, 8'h0);
        apb(1'b1, `AOLC_IDX_IFACE, 8'h0);
    endtask : t_pins

    task automatic t_latency(input logic [13:0] exp);
        int n;
        cyc(20);
        rawSample <= 14'h1a5;
        @(posedge clk);
        rawSample <= 14'h0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            #1;
        end while (outData !== exp && n < 30);
        `CHK(n, 10)
    endtask : t_latency

    task automatic t_correct;
        logic [31:0] e1;
        apb(1'b1, `AOLC_IDX_SHORTPATH, 8'h08);
        apb(1'b1, `AOLC_IDX_FORMAT, 8'h20);
        cyc(300);
        `CHK(correctionActive, 1'b1)
        apb(1'b1, `AOLC_IDX_LOOP, 8'h80);
        apb(1'b0, `AOLC_IDX_STATUS, 8'h0);
        e1 = rdData;
        `CHK({e1[30], e1[13]}, 2'h3)
        cyc(200);
        apb(1'b0, `AOLC_IDX_STATUS, 8'h0);
        `CHK(rdData[13:0], e1[13:0])
        `CHK(outData, 14'h0 - e1[13:0])
        apb(1'b1, `AOLC_IDX_SHORTPATH, 8'h0);
        cyc(3);
        `CHK(correctionActive, 1'b0)
        apb(1'b1, `AOLC_IDX_FORMAT, 8'h0);
        apb(1'b0, `AOLC_IDX_STATUS, 8'h0);
        `CHK(rdData[13:0], 14'h0)
        apb(1'b1, `AOLC_IDX_LOOP, 8'h0);
    endtask : t_correct

    task automatic t_buffer;
        slowMode <= 1'b1;
        cyc(20);
        holdOff <= 1'b1;
        cyc(30);
        `CHK(bufferReady, 1'b0)
        apb(1'b0, `AOLC_IDX_STATUS, 8'h0);
        `CHK(rdData[31], 1'b1)
        holdOff  <= 1'b0;
        slowMode <= 1'b0;
        cyc(30);
        `CHK(bufferReady, 1'b1)
    endtask : t_buffer

    initial begin
        cyc(4);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_speed();
        t_pins();
        t_latency(14'h1a5);
        formatPin <= 1'b1;
        t_latency(14'h21a5);
        formatPin <= 1'b0;
        t_correct();
        t_buffer();
        end_of_test();
    end
endmodule : tb
